// file: hw/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
// register byte offsets
`define OFS_TASK 8'h00
`define OFS_STATUS 8'h04
`define OFS_EVENTS 8'h08
`define OFS_RES 8'h0c
`define OFS_OVS 8'h10
`define OFS_RATE 8'h14
`define OFS_PTR 8'h18
`define OFS_MAXCNT 8'h1c
`define OFS_AMOUNT 8'h20
`define OFS_CH0 8'h40
// task bits
`define TSK_START 0
`define TSK_SAMPLE 1
`define TSK_STOP 2
`define TSK_CAL 3
// event numbers; the EVENTS register holds number n at bit 5 - n
`define EV_STARTED 0
`define EV_END 1
`define EV_DONE 2
`define EV_RDONE 3
`define EV_CALDONE 4
`define EV_STOPPED 5
// channel config fields
`define CH_POSITIVE_INPUT_SELECT 0
`define CH_NEGATIVE_INPUT_SELECT 1
`define CH_DIFF 2
`define CH_BURST 3
`define CH_ACQUIRE_DURATION_LSB 4
`define CH_ACQUIRE_DURATION_W 3
// timing
`define TCONV_NS 2000
`define TCONV_CYC ((`TCONV_NS + 24) / 25)
`define TCAL_CYC 16
`endif

// file: hw/adc_seq_pkg.sv
package adc_seq_pkg;
	typedef struct packed {
		logic [2:0] acquire_duration;
		logic burst;
		logic diff;
		logic negative_input_select;
		logic positive_input_select;
	} ch_cfg_t;
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_acq = 3'b001,
		st_conv = 3'b010,
		st_write = 3'b011,
		st_cal = 3'b100,
		st_wait = 3'b101
	} seq_state_t;
	typedef struct packed {
		logic started;
		logic ended;
		logic done;
		logic rdone;
		logic caldone;
		logic stopped;
	} events_t;
endpackage

// file: hw/adc_res_pack.sv
`timescale 1ns/1ps
// packs 16-bit results two per word, low half first
module adc_res_pack
(
	input wire logic mclk, // clock
	input wire logic resetn, // async reset
	input wire logic clr, // start of buffer
	input wire logic push, // result valid
	input wire logic [15:0] data, // result
	input wire logic flush, // write this result alone as a low half
	output logic wr, // word write pulse
	output logic [31:0] wdata, // word
	output logic [3:0] be // byte enables
);
	logic [15:0] low_q;
	logic half_q;
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			low_q <= 16'h0000;
			half_q <= 1'b0;
			wr <= 1'b0;
			wdata <= 32'h0;
			be <= 4'h0;
		end
		else
		begin
			wr <= 1'b0;
			if (clr)
				half_q <= 1'b0;
			else if (push && half_q)
			begin
				wr <= 1'b1; // R20
				wdata <= {data, low_q};
				be <= 4'hf;
				half_q <= 1'b0;
			end
			else if (push && flush)
			begin
				wr <= 1'b1; // R21
				wdata <= {16'h0000, data};
				be <= 4'h3;
			end
			else if (push)
			begin
				low_q <= data;
				half_q <= 1'b1;
			end
		end
endmodule

// file: hw/adc_acc.sv
`timescale 1ns/1ps
// oversampling accumulator
module adc_acc #(parameter int W = 20)
(
	input wire logic mclk, // clock
	input wire logic resetn, // async reset
	input wire logic clr, // clear sum
	input wire logic add, // add sample
	input wire logic [15:0] smp, // signed sample
	input wire logic [3:0] exp, // averaging exponent
	output logic [15:0] avg // averaged value
);
	logic signed [W+15:0] sum_q;
	logic signed [W+15:0] sh;
	if (W < 8) $error("acc width too small");
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			sum_q <= '0;
		else if (clr)
			sum_q <= '0;
		else if (add)
			sum_q <= sum_q + {{W{smp[15]}}, smp};
	always_comb
	begin
		// shift on the signed variable so that negative sums round down
		sh = sum_q + (add ? {{W{smp[15]}}, smp} : '0);
		sh = sh >>> exp;
		avg = sh[15:0];
	end
endmodule

// file: hw/adc_sample_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_map.svh"
//--------------------------------------------------------------
// Function
// R1: resolution 8/10/12, 14 only oversampled; code has no 14-bit mode, setting 3 gives 12
// R2: eight channels, each single or differential
// R3: code scaled by two^(res-m), m=diff
// R4: channels default single-ended, negative grounded
// R5: positive select set enables channel
// R6: negative select ignored unless differential
// R7: one enabled one-shot, several means scan
// R8: scan converts every enabled channel per task
// R9: software avoids oversampling in scan
// R10: busy status toggles per conversion
// R11: sample task starts acquisition, channel duration
// R12: done each conversion, result-done without averaging
// R13: average two^exponent conversions per result
// R14: result-done only when average complete
// R15: burst bit runs all conversions back-to-back
// R16: local timer samples periodically until stop
// R17: software uses one channel with timer
// R18: trim task raises trim, done, result-done
// R19: results stored 16-bit two's complement
// R20: two results per word, earlier low
// R21: odd capacity writes final low half
// R22: software limits trigger rate
// R23: scan ascending index, skipping disabled
// R24: end event when capacity reached
// R25: stop terminates, stopped always raised
// R26: base pointer double-buffered
// R27: readable transferred count since start
//--------------------------------------------------------------
module adc_sample_sequencer
(
	input wire logic mclk, // 40 MHz clock
	input wire logic resetn, // async reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic [3:0] task_in, // interconnect task pulses
	output adc_seq_pkg::events_t events_out, // one-cycle event pulses
	output logic [2:0] conv_chan, // channel under conversion
	output logic conv_start, // start of conversion pulse
	input wire logic [11:0] conv_code, // raw converter code
	output logic [31:0] dma_addr, // ram word address
	output logic [31:0] dma_wdata, // ram data
	output logic [3:0] dma_be, // ram byte enables
	output logic dma_write, // ram write request, held until ready
	input wire logic dma_ready // ram accepts
);
	localparam int nch = 8; // R2
	localparam int tconv = `TCONV_CYC;
	logic [1:0] res_q;
	logic [3:0] ovs_q;
	logic rate_mode_q;
	logic [10:0] rate_cc_q;
	logic [31:0] ptr_q, ptr_live_q;
	logic [14:0] maxcnt_q, amount_q;
	adc_seq_pkg::ch_cfg_t cfg_q [nch];
	adc_seq_pkg::seq_state_t st_q;
	adc_seq_pkg::events_t ev_d, ev_q, ev_flag_q;
	logic [2:0] ch_q;
	logic [15:0] cnt_q;
	logic [15:0] rate_q;
	logic [15:0] nsmp_q;
	logic busy_q, running_q, ack_q;
	logic [3:0] tsk;
	logic [15:0] smp, avg;
	logic [7:0] en;
	logic push, wr;
	logic [31:0] wdata;
	logic [3:0] be;
	logic avg_last;

	//--------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------
	// next enabled channel at or above start
	function automatic logic [3:0] next_ch(input logic [7:0] m, input logic [3:0] s);
		logic [3:0] r;
		r = 4'h8;
		for (int i = 7; i >= 0; i--)
			if (m[i] && (i >= s)) r = 4'(i); // R23
		return r;
	endfunction
	function automatic logic [15:0] acquire_duration_cyc(input logic [2:0] t);
		logic [15:0] r;
		case (t)
			3'd0: r = 16'd120;
			3'd1: r = 16'd200;
			3'd2: r = 16'd400;
			3'd3: r = 16'd600;
			3'd4: r = 16'd800;
			default: r = 16'd1600;
		endcase
		return r;
	endfunction

	generate
		for (genvar g = 0; g < nch; g++)
		begin : g_en
			assign en[g] = cfg_q[g].positive_input_select; // R5
		end
	endgenerate

	wire scan = ($countones(en) > 1); // R7
	wire [3:0] first_ch = next_ch(en, 4'h0);
	wire [3:0] after_ch = next_ch(en, 4'(ch_q) + 4'h1);
	wire cur_diff = cfg_q[ch_q].diff & cfg_q[ch_q].negative_input_select; // R6
	wire [15:0] ovs_n = 16'h1 << ovs_q;

	//--------------------------------------------------------------
	// register bus
	//--------------------------------------------------------------
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign tsk = task_in | ((avs_write & ack_q && avs_address == `OFS_TASK) ?
		avs_writedata[3:0] : 4'h0);
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read | avs_write) & ~ack_q;

	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			res_q <= 2'd1;
			ovs_q <= 4'h0;
			rate_mode_q <= 1'b0;
			rate_cc_q <= 11'd80;
			ptr_q <= 32'h0;
			maxcnt_q <= 15'h0;
			for (int i = 0; i < nch; i++) cfg_q[i] <= '0; // R4
		end
		else if (avs_write && ack_q)
			case (avs_address)
				`OFS_RES: res_q <= avs_writedata[1:0];
				`OFS_OVS: ovs_q <= avs_writedata[3:0];
				`OFS_RATE:
				begin
					rate_cc_q <= avs_writedata[10:0];
					rate_mode_q <= avs_writedata[12];
				end
				`OFS_PTR: ptr_q <= avs_writedata; // R26
				`OFS_MAXCNT: maxcnt_q <= avs_writedata[14:0];
				default:
					if (avs_address[7:5] == 3'b010)
						cfg_q[avs_address[4:2]] <= avs_writedata[6:0];
			endcase

	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			avs_readdata <= 32'h0;
		else if (avs_read && !ack_q)
			case (avs_address)
				`OFS_STATUS: avs_readdata <= {30'h0, running_q, busy_q}; // R10
				`OFS_EVENTS: avs_readdata <= {26'h0, ev_flag_q};
				`OFS_RES: avs_readdata <= {30'h0, res_q};
				`OFS_OVS: avs_readdata <= {28'h0, ovs_q};
				`OFS_RATE: avs_readdata <= {19'h0, rate_mode_q, 1'b0, rate_cc_q};
				`OFS_PTR: avs_readdata <= ptr_q;
				`OFS_MAXCNT: avs_readdata <= {17'h0, maxcnt_q};
				`OFS_AMOUNT: avs_readdata <= {17'h0, amount_q}; // R27
				default:
					avs_readdata <= (avs_address[7:5] == 3'b010) ?
						{25'h0, cfg_q[avs_address[4:2]]} : 32'h0;
			endcase

	// sticky event flags: set wins over write-one-to-clear
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			ev_flag_q <= '0;
		else if (avs_write && ack_q && avs_address == `OFS_EVENTS)
			ev_flag_q <= (ev_flag_q & ~avs_writedata[5:0]) | ev_d;
		else
			ev_flag_q <= ev_flag_q | ev_d;

	//--------------------------------------------------------------
	// result formatting
	//--------------------------------------------------------------
	always_comb
	begin
		logic signed [15:0] raw;
		// single-ended codes are unsigned full scale; differential is signed half scale
		raw = cur_diff ? {{4{conv_code[11]}}, conv_code} : {4'h0, conv_code}; // R3
		case (res_q)
			2'd0: smp = raw >>> 4;
			2'd1: smp = raw >>> 2;
			default: smp = raw; // R1 R19
		endcase
	end

	adc_acc #(.W(20)) u_acc
	(
		.mclk(mclk),
		.resetn(resetn),
		.clr(push || tsk[`TSK_STOP] || tsk[`TSK_START]),
		.add(st_q == adc_seq_pkg::st_conv && cnt_q == 16'h0 && ovs_q != 4'h0),
		.smp(smp),
		.exp(ovs_q),
		.avg(avg)
	);

	//--------------------------------------------------------------
	// sequencer
	//--------------------------------------------------------------
	assign avg_last = (ovs_q == 4'h0) || (nsmp_q + 16'h1 == ovs_n); // R13
	wire conv_end = (st_q == adc_seq_pkg::st_conv) && (cnt_q == 16'h0);
	wire full = (amount_q + 15'h1 >= maxcnt_q);
	wire odd_last = maxcnt_q[0] && (amount_q + 15'h1 == maxcnt_q);
	wire stopped_req = tsk[`TSK_STOP];

	always_comb
	begin
		ev_d = '0;
		ev_d.started = tsk[`TSK_START];
		ev_d.stopped = stopped_req; // R25
		ev_d.done = conv_end; // R12
		ev_d.rdone = conv_end && avg_last; // R14
		ev_d.ended = push && running_q && full && !tsk[`TSK_START]; // R24
		if (st_q == adc_seq_pkg::st_cal && cnt_q == 16'h0)
		begin
			ev_d.caldone = 1'b1; // R18
			ev_d.done = 1'b1;
			ev_d.rdone = 1'b1;
		end
	end
	assign push = conv_end && avg_last;

	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			st_q <= adc_seq_pkg::st_idle;
			ch_q <= 3'h0;
			cnt_q <= 16'h0;
			nsmp_q <= 16'h0;
			busy_q <= 1'b0;
			conv_start <= 1'b0;
		end
		else
		begin
			conv_start <= 1'b0;
			if (stopped_req)
			begin
				st_q <= adc_seq_pkg::st_idle; // R25
				busy_q <= 1'b0;
				nsmp_q <= 16'h0;
			end
			else
				case (st_q)
					adc_seq_pkg::st_idle, adc_seq_pkg::st_wait:
						if (tsk[`TSK_CAL])
						begin
							st_q <= adc_seq_pkg::st_cal;
							cnt_q <= 16'(`TCAL_CYC);
						end
						else if ((tsk[`TSK_SAMPLE] || (st_q == adc_seq_pkg::st_wait &&
							rate_q == 16'h0)) && first_ch != 4'h8)
						begin
							ch_q <= first_ch[2:0];
							st_q <= adc_seq_pkg::st_acq; // R11
							cnt_q <= acquire_duration_cyc(cfg_q[first_ch[2:0]].acquire_duration);
						end
					adc_seq_pkg::st_acq:
						if (cnt_q == 16'h0)
						begin
							st_q <= adc_seq_pkg::st_conv;
							cnt_q <= 16'(tconv);
							conv_start <= 1'b1;
							busy_q <= ~busy_q; // R10
						end
						else
							cnt_q <= cnt_q - 16'h1;
					adc_seq_pkg::st_conv:
						if (cnt_q == 16'h0)
						begin
							busy_q <= ~busy_q; // R10
							nsmp_q <= avg_last ? 16'h0 : nsmp_q + 16'h1;
							if (scan && after_ch != 4'h8)
							begin
								ch_q <= after_ch[2:0]; // R8
								st_q <= adc_seq_pkg::st_acq;
								cnt_q <= acquire_duration_cyc(cfg_q[after_ch[2:0]].acquire_duration);
							end
							else if (!avg_last && cfg_q[ch_q].burst)
							begin
								st_q <= adc_seq_pkg::st_acq; // R15
								cnt_q <= acquire_duration_cyc(cfg_q[ch_q].acquire_duration);
							end
							else if (rate_mode_q)
								st_q <= adc_seq_pkg::st_wait; // R16
							else
								st_q <= adc_seq_pkg::st_idle;
						end
						else
							cnt_q <= cnt_q - 16'h1;
					adc_seq_pkg::st_cal:
						if (cnt_q == 16'h0)
							st_q <= adc_seq_pkg::st_idle;
						else
							cnt_q <= cnt_q - 16'h1;
					default:
						st_q <= adc_seq_pkg::st_idle;
				endcase
		end

	// local rate timer counts from the start of each sample
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			rate_q <= 16'h0;
		else if (st_q == adc_seq_pkg::st_acq && ch_q == first_ch[2:0] && cnt_q != 16'h0 &&
			rate_q == 16'h0)
			rate_q <= {5'h0, rate_cc_q} * 16'd4; // R16
		else if (rate_q != 16'h0)
			rate_q <= rate_q - 16'h1;

	//--------------------------------------------------------------
	// ram transfer
	//--------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			running_q <= 1'b0;
			amount_q <= 15'h0;
			ptr_live_q <= 32'h0;
		end
		else if (tsk[`TSK_START])
		begin
			running_q <= 1'b1;
			amount_q <= 15'h0;
			ptr_live_q <= ptr_q; // R26
		end
		else
		begin
			// a result finishing on the stop edge is still counted
			if (push && running_q)
				amount_q <= amount_q + 15'h1; // R27
			if (stopped_req || (push && running_q && full))
				running_q <= 1'b0; // R24 R25
		end

	// index of the newest result; a word sits at the address of its lower half
	wire [14:0] last_idx = amount_q - 15'h1;

	adc_res_pack u_pack
	(
		.mclk(mclk),
		.resetn(resetn),
		.clr(tsk[`TSK_START]),
		.push(push && running_q),
		.data((ovs_q != 4'h0) ? avg : smp), // R19
		.flush(odd_last),
		.wr(wr),
		.wdata(wdata),
		.be(be)
	);

	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			dma_write <= 1'b0;
			dma_wdata <= 32'h0;
			dma_be <= 4'h0;
			dma_addr <= 32'h0;
		end
		else if (wr)
		begin
			dma_write <= 1'b1; // R20
			dma_wdata <= wdata;
			dma_be <= be;
			dma_addr <= ptr_live_q + {16'h0, last_idx[14:1], 2'b00}; // R20 R21
		end
		else if (dma_ready)
			dma_write <= 1'b0;

	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			ev_q <= '0;
		else
			ev_q <= ev_d;
	assign events_out = ev_q;
	assign conv_chan = ch_q;

	a_done_rdone: assert property (@(posedge mclk) disable iff (!resetn)
		(ovs_q == 4'h0 && ev_d.done) |-> ev_d.rdone) else $error("rdone missing"); // R12
	a_stop_event: assert property (@(posedge mclk) disable iff (!resetn)
		tsk[`TSK_STOP] |=> events_out.stopped) else $error("no stopped"); // R25
	a_busy_toggle: assert property (@(posedge mclk) disable iff (!resetn)
		conv_end |=> busy_q != $past(busy_q)) else $error("busy no toggle"); // R10
	a_cal_events: assert property (@(posedge mclk) disable iff (!resetn)
		ev_d.caldone |-> ev_d.done && ev_d.rdone) else $error("cal events"); // R18
	a_stop_idle: assert property (@(posedge mclk) disable iff (!resetn)
		tsk[`TSK_STOP] |=> st_q == adc_seq_pkg::st_idle) else $error("stop ignored"); // R25
	a_start_amount: assert property (@(posedge mclk) disable iff (!resetn)
		tsk[`TSK_START] |=> amount_q == 15'h0) else $error("amount not cleared"); // R27
	a_end_full: assert property (@(posedge mclk) disable iff (!resetn)
		ev_d.ended |=> amount_q == maxcnt_q) else $error("end early"); // R24
	a_rdone_avg: assert property (@(posedge mclk) disable iff (!resetn)
		(ev_d.rdone && !ev_d.caldone) |-> avg_last) else $error("rdone early"); // R14
	sequence s_sample_idle;
		tsk[`TSK_SAMPLE] && !tsk[`TSK_STOP] && !tsk[`TSK_CAL] &&
			st_q == adc_seq_pkg::st_idle && first_ch != 4'h8;
	endsequence
	sequence s_acq_begun;
		st_q == adc_seq_pkg::st_acq && ch_q == first_ch[2:0] &&
			cnt_q == acquire_duration_cyc(cfg_q[ch_q].acquire_duration);
	endsequence
	a_sample_acq: assert property (@(posedge mclk) disable iff (!resetn)
		s_sample_idle |=> s_acq_begun) else $error("no acquisition"); // R11 R23
endmodule

// file: test/adc_far_model.sv
`timescale 1ns/1ps
// far side: converter code source and result ram with random stalls
module adc_far_model
(
	input wire logic mclk, // clock
	input wire logic resetn, // async reset, active low
	input wire logic conv_start, // conversion begins
	input wire logic [2:0] conv_chan, // channel converted
	output logic [11:0] conv_code, // code handed back
	input wire logic [31:0] dma_addr, // ram word address
	input wire logic [31:0] dma_wdata, // ram word
	input wire logic [3:0] dma_be, // byte lanes
	input wire logic dma_write, // write request
	output logic dma_ready, // write accepted
	input wire logic slow // stall often
);
	logic [31:0] wq [$];
	logic [3:0] bq [$];
	logic [31:0] aq [$];
	logic [2:0] chq [$];
	logic [11:0] cq [$];
	logic [11:0] code;
	initial
	begin
		conv_code = 12'h000;
		dma_ready = 1'b0;
	end
	// ram takes a word only at an edge with ready high
	always @(posedge mclk)
	begin
		dma_ready <= slow ? ($urandom % 4 == 0) : 1'b1;
		if (resetn && dma_write && dma_ready)
		begin
			wq.push_back(dma_wdata);
			bq.push_back(dma_be);
			aq.push_back(dma_addr);
		end
		// a fresh random code for each conversion
		if (resetn && conv_start)
		begin
			code = 12'($urandom);
			conv_code <= code;
			cq.push_back(code);
			chq.push_back(conv_chan);
		end
	end
endmodule

// file: test/test_adc_sample_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_map.svh"
module test_adc_sample_sequencer;
	logic mclk, resetn, avs_read, avs_write, avs_waitrequest, conv_start, dma_write;
	logic dma_ready, slow;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, dma_addr, dma_wdata, d;
	logic [3:0] avs_byteenable, task_in, dma_be;
	logic [2:0] conv_chan;
	logic [11:0] conv_code;
	adc_seq_pkg::events_t events_out;
	localparam int ev_st = 5;
	localparam int ev_end = 4;
	localparam int ev_dn = 3;
	localparam int ev_rd = 2;
	localparam int ev_cal = 1;
	localparam int ev_sp = 0;
	int ev_n [6];
	int scan_ch [5] = '{1, 2, 5, 1, 2};
	int n_conv, miscompares, cmp_count, s, c0, d0, r0, q0;
	adc_sample_sequencer uut (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .task_in(task_in), .events_out(events_out),
		.conv_chan(conv_chan), .conv_start(conv_start), .conv_code(conv_code),
		.dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_be(dma_be), .dma_write(dma_write),
		.dma_ready(dma_ready));
	adc_far_model far (.mclk(mclk), .resetn(resetn), .conv_start(conv_start),
		.conv_chan(conv_chan), .conv_code(conv_code), .dma_addr(dma_addr),
		.dma_wdata(dma_wdata), .dma_be(dma_be), .dma_write(dma_write),
		.dma_ready(dma_ready), .slow(slow));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		for (int i = 0; i < 6; i++)
			if (events_out[i] === 1'b1)
				ev_n[i]++;
		if (conv_start === 1'b1)
			n_conv++;
	end
	// stored value for a raw code: signed only when differential, shifted to resolution
	function automatic logic [15:0] xcode(input logic [11:0] c, input logic df, input int sh);
		logic signed [15:0] v;
		v = df ? {{4{c[11]}}, c} : {4'h0, c};
		return 16'(v >>> sh);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// request held until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge mclk);
		while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd);
	endtask
	task automatic go(input int b);
		task_in <= 4'h1 << b;
		@(posedge mclk);
		task_in <= 4'h0;
		@(posedge mclk);
	endtask
	task automatic wait_ev(input int i, input int tgt);
		while (ev_n[i] < tgt)
			@(posedge mclk);
	endtask
	task automatic conclude;
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		conclude();
	end
	initial
	begin
		resetn = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		task_in = 4'h0;
		slow = 1'b0;
		void'($urandom(84411));
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		bus(1'b0, `OFS_AMOUNT, 32'h0);
		chk("amount at reset", d, 32'h0);
		wr(8'hfc, 32'hffffffff);
		bus(1'b0, 8'hfc, 32'h0);
		chk("unmapped read", d, 32'h0);
		// scan over 1, 2, 5; channel 3 has only its negative select
		slow <= 1'b1;
		wr(`OFS_RES, 32'h2);
		for (int n = 0; n < 8; n++)
			wr(8'(`OFS_CH0 + 4 * n), (n == 1 || n == 2 || n == 5) ? 32'h1 : 32'(n == 3) << 1);
		wr(`OFS_PTR, 32'h100);
		wr(`OFS_MAXCNT, 32'h5);
		go(`TSK_START);
		wait_ev(ev_st, 1);
		wr(`OFS_PTR, 32'h400);
		go(`TSK_SAMPLE);
		wait_ev(ev_dn, 3);
		go(`TSK_SAMPLE);
		wait_ev(ev_end, 1);
		repeat (150) @(posedge mclk);
		for (int i = 0; i < 5; i++)
			chk("scan channel", 32'(far.chq[i]), scan_ch[i]);
		for (int w = 0; w < 2; w++)
			chk("packed word", far.wq[w], {xcode(far.cq[2 * w + 1], 1'b0, 0),
				xcode(far.cq[2 * w], 1'b0, 0)});
		chk("last word low", 32'(far.wq[2][15:0]), 32'(xcode(far.cq[4], 1'b0, 0)));
		chk("last word lanes", 32'(far.bq[2]), 32'h3);
		chk("words written", far.wq.size(), 3);
		for (int w = 0; w < 3; w++)
			chk("word address", far.aq[w], 32'(32'h100 + 4 * w));
		bus(1'b0, `OFS_AMOUNT, 32'h0);
		chk("amount", d, 32'h5);
		chk("end count", ev_n[ev_end], 1);
		chk("result per done", ev_n[ev_rd], ev_n[ev_dn]);
		for (int k = 1; k <= 2; k++)
		begin
			wr(`OFS_TASK, 32'h1 << `TSK_STOP);
			wait_ev(ev_sp, k);
			chk("stopped", ev_n[ev_sp], k);
		end
		d0 = ev_n[ev_dn];
		r0 = ev_n[ev_rd];
		go(`TSK_CAL);
		wait_ev(ev_cal, 1);
		repeat (2) @(posedge mclk);
		chk("trim done", ev_n[ev_dn] - d0, 1);
		chk("trim result", ev_n[ev_rd] - r0, 1);
		// one channel only while averaging
		wr(8'(`OFS_CH0 + 8), 32'h0);
		wr(8'(`OFS_CH0 + 20), 32'h0);
		wr(8'(`OFS_CH0 + 4), 32'h9);
		wr(`OFS_RES, 32'h1);
		wr(`OFS_OVS, 32'h2);
		wr(`OFS_MAXCNT, 32'h1);
		go(`TSK_START);
		wait_ev(ev_st, 2);
		c0 = n_conv;
		d0 = ev_n[ev_dn];
		r0 = ev_n[ev_rd];
		go(`TSK_SAMPLE);
		wait_ev(ev_end, 2);
		repeat (60) @(posedge mclk);
		chk("burst conversions", n_conv - c0, 4);
		chk("burst dones", ev_n[ev_dn] - d0, 4);
		chk("averaged results", ev_n[ev_rd] - r0, 1);
		s = 0;
		for (int i = 1; i <= 4; i++)
			s += far.cq[far.cq.size() - i] >> 2;
		chk("average", 32'(far.wq[3][15:0]), 32'(16'(s / 4)));
		chk("lone result lanes", 32'(far.bq[3]), 32'h3);
		chk("lone result address", far.aq[3], 32'h400);
		// local timer with a single channel and no averaging
		wr(`OFS_OVS, 32'h0);
		// differential at eight bits; a period of 256 cycles outlasts acquire plus convert
		wr(8'(`OFS_CH0 + 4), 32'h7);
		wr(`OFS_RES, 32'h0);
		wr(`OFS_RATE, 32'h1040);
		wr(`OFS_MAXCNT, 32'h64);
		go(`TSK_START);
		wait_ev(ev_st, 3);
		d0 = ev_n[ev_dn];
		q0 = far.cq.size();
		go(`TSK_SAMPLE);
		wait_ev(ev_dn, d0 + 3);
		wr(`OFS_TASK, 32'h1 << `TSK_STOP);
		wait_ev(ev_sp, 3);
		chk("timer stopped", ev_n[ev_sp], 3);
		c0 = n_conv;
		repeat (400) @(posedge mclk);
		chk("timer halted", n_conv, c0);
		chk("timer word", far.wq[4], {xcode(far.cq[q0 + 1], 1'b1, 4),
			xcode(far.cq[q0], 1'b1, 4)});
		chk("timer address", far.aq[4], 32'h400);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk("status idle", d, 32'h0);
		bus(1'b0, `OFS_EVENTS, 32'h0);
		chk("event flags", d, 32'h3f);
		wr(`OFS_EVENTS, 32'h3f);
		bus(1'b0, `OFS_EVENTS, 32'h0);
		chk("flags cleared", d, 32'h0);
		conclude();
	end
endmodule
